// ---- include/arb_pkg.sv ----
package arb_pkg;
	// register bus shape
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [3:0] CTRL_OFF = 4'h0;
	localparam logic [3:0] DIV_OFF  = 4'h4;
	localparam logic [3:0] STAT_OFF = 4'h8;
	localparam logic [3:0] DATA_OFF = 4'hC;

	// serial_control_one fields
	localparam int RX_EN_POS = 0;
	localparam int NINE_POS  = 1;

	// serial_status_register fields
	localparam int FULL_POS   = 0;
	localparam int NOISE_POS  = 1;
	localparam int FRAME_POS  = 2;
	localparam int ACTIVE_POS = 3;

	// oversample timing
	localparam int SYS_HZ    = 100_000_000;
	localparam int BAUD_HZ   = 115_200;
	localparam int OS_FACTOR = 16;
	localparam logic [15:0] DIV_RESET = 16'(SYS_HZ / (OS_FACTOR * BAUD_HZ) - 1);

	// oversample period labels
	localparam logic [4:0] RT_FIRST = 5'h01;
	localparam logic [4:0] RT_3     = 5'h03;
	localparam logic [4:0] RT_5     = 5'h05;
	localparam logic [4:0] RT_7     = 5'h07;
	localparam logic [4:0] RT_8     = 5'h08;
	localparam logic [4:0] RT_9     = 5'h09;
	localparam logic [4:0] RT_10    = 5'h0A;
	localparam logic [4:0] RT_LAST  = 5'h10;

	// frame layout, bit index 0 is the start bit
	localparam logic [3:0] STOP_IDX_8 = 4'h9;
	localparam logic [3:0] STOP_IDX_9 = 4'hA;

	typedef enum logic [1:0] {
		ARB_HUNT  = 2'b00,
		ARB_START = 2'b01,
		ARB_FRAME = 2'b10
	} arb_state_t;
endpackage

// ---- logic/arb_os_tick.sv ----
`timescale 1ns/1ns
module arb_os_tick import arb_pkg::*; #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] div,
	// oversample enable
	output logic                  tick
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} arb_div_state_t;

	arb_div_state_t q_ff;
	arb_div_state_t nxt_q;

	// one tick every div+1 clocks keeps the receiver in one clock domain
	always_comb begin
		nxt_q      = q_ff;
		nxt_q.tick = 1'b0;
		if (!run) begin
			nxt_q.cnt = div;
		end else if (q_ff.cnt == '0) begin
			nxt_q.cnt  = div;
			nxt_q.tick = 1'b1;
		end else begin
			nxt_q.cnt = q_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q_ff <= '0;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end

	assign tick = q_ff.tick;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_tick_pulse: assert property (ce && tick && div != '0 |=> !tick)
		else $error("oversample tick longer than one cycle");
endmodule

// ---- logic/arb_rx_bit.sv ----
// Functional notes
// - line is oversampled at sixteen times baud, periods one to sixteen.
// - setting receiver enable starts start-bit hunting with no prior alignment.
// - hunting samples every period into a three-deep history.
// - low without three prior highs is not a start edge.
// - low after three highs is period one; receiver active set.
// - periods three and five both high reject the candidate start.
// - any two of periods three, five, seven high reject the candidate.
// - in frame, period restarts at one on each fall or after sixteen.
// - after the stop bit the receiver goes back to hunting.
// - each data and stop bit decided by majority of periods eight, nine, ten.
// - data and ninth bits are shifted in, start and stop not.
// - disagreeing mid-bit samples set the frame noise indicator.
// - start bit with disagreeing periods three, five, seven sets noise.
// - frame noise is reported with receive full at transfer.
// - rejected false starts do not add noise to the next frame.
// - start accepted by early samples even if mid-bit majority is high.
// - low stop bit sets framing error.
// - frame-length select one takes a ninth data bit, stored at transfer.
// - completed character transfers unless receive full already set.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module arb_rx_bit import arb_pkg::*; #(
	parameter int DIV_W = 16
) (
	// clock, reset, enable
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	// serial line
	input  wire logic              rx_pin,
	// status
	output logic                   receiver_active_flag,
	output logic                   receive_full_flag
);
	typedef struct packed {
		logic             meta;
		logic             sync;
		arb_state_t       st;
		logic [4:0]       rt;
		logic [2:0]       hist;
		logic             s3;
		logic             s5;
		logic             s8;
		logic             s9;
		logic [3:0]       bitn;
		logic [8:0]       shift;
		logic             noise;
		logic             active;
		logic             en;
		logic             nine;
		logic [DIV_W-1:0] div;
		logic [8:0]       data;
		logic             full;
		logic             nf;
		logic             fe;
		logic             armed;
		logic [DATA_W-1:0] rdata;
	} arb_rx_state_t;

	arb_rx_state_t q_ff;
	arb_rx_state_t nxt_q;
	logic          tick;
	logic          go;
	logic [4:0]    lbl;
	logic          fall;
	logic          maj;
	logic          xfer;
	logic          noise_fin;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic same3(input logic a, input logic b, input logic c);
		return (a == b) && (b == c);
	endfunction

	arb_os_tick #(.DIV_W(DIV_W)) u_tick (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.run     (q_ff.en),
		.div     (q_ff.div),
		.tick    (tick)
	);

	assign go   = tick;
	assign fall = q_ff.hist[0] & ~q_ff.sync;
	assign maj  = maj3(q_ff.s8, q_ff.s9, q_ff.sync);

	always_comb begin
		nxt_q      = q_ff;
		xfer       = 1'b0;
		noise_fin  = 1'b0;
		lbl        = (q_ff.rt >= RT_LAST) ? RT_FIRST : q_ff.rt + 5'h01;
		// only the second flop is ever read
		nxt_q.meta  = rx_pin;
		nxt_q.sync  = q_ff.meta;
		nxt_q.rdata = '0;

		if (wr_en) begin
			unique case (addr)
				CTRL_OFF: begin
					nxt_q.en   = wr_data[RX_EN_POS];
					nxt_q.nine = wr_data[NINE_POS];
				end
				DIV_OFF: nxt_q.div = wr_data[DIV_W-1:0];
				default: ;
			endcase
		end
		if (rd_en) begin
			unique case (addr)
				STAT_OFF: begin
					nxt_q.rdata[FULL_POS]   = q_ff.full;
					nxt_q.rdata[NOISE_POS]  = q_ff.nf;
					nxt_q.rdata[FRAME_POS]  = q_ff.fe;
					nxt_q.rdata[ACTIVE_POS] = q_ff.active;
					nxt_q.armed             = 1'b1;
				end
				DATA_OFF: begin
					nxt_q.rdata[8:0] = q_ff.data;
					// status read then data read clears the flags
					if (q_ff.armed) begin
						nxt_q.full = 1'b0;
						nxt_q.nf   = 1'b0;
						nxt_q.fe   = 1'b0;
					end
					nxt_q.armed = 1'b0;
				end
				CTRL_OFF: begin
					nxt_q.rdata[RX_EN_POS] = q_ff.en;
					nxt_q.rdata[NINE_POS]  = q_ff.nine;
				end
				DIV_OFF: nxt_q.rdata[DIV_W-1:0] = q_ff.div;
				default: ;
			endcase
		end

		// receiver follows the bus so that a set beats a same-cycle clear
		if (!q_ff.en) begin
			nxt_q.st     = ARB_HUNT;
			nxt_q.active = 1'b0;
			nxt_q.hist   = '0;
			nxt_q.rt     = '0;
		end else if (go) begin
			nxt_q.hist = {q_ff.hist[1:0], q_ff.sync};
			unique case (q_ff.st)
				ARB_HUNT: begin
					// enable alone starts the hunt, no earlier alignment kept
					if (!q_ff.sync && q_ff.hist == 3'b111) begin
						nxt_q.st     = ARB_START;
						nxt_q.rt     = RT_FIRST;
						nxt_q.active = 1'b1;
						nxt_q.noise  = 1'b0;
					end
				end
				ARB_START: begin
					nxt_q.rt = lbl;
					if (lbl == RT_3) begin
						nxt_q.s3 = q_ff.sync;
					end else if (lbl == RT_5) begin
						if (q_ff.s3 && q_ff.sync) begin
							nxt_q.st     = ARB_HUNT;
							nxt_q.active = 1'b0;
						end else begin
							nxt_q.s5 = q_ff.sync;
						end
					end else if (lbl == RT_7) begin
						if (maj3(q_ff.s3, q_ff.s5, q_ff.sync)) begin
							nxt_q.st     = ARB_HUNT;
							nxt_q.active = 1'b0;
						end else begin
							// accepted: period one plus two of three are low
							nxt_q.noise = !same3(q_ff.s3, q_ff.s5, q_ff.sync);
							nxt_q.st    = ARB_FRAME;
							nxt_q.bitn  = '0;
						end
					end
				end
				ARB_FRAME: begin
					// resync on every fall keeps small baud errors from adding up
					nxt_q.rt = fall ? RT_FIRST : lbl;
					if (!fall && lbl == RT_8) begin
						nxt_q.s8 = q_ff.sync;
					end else if (!fall && lbl == RT_9) begin
						nxt_q.s9 = q_ff.sync;
					end else if (!fall && lbl == RT_10) begin
						// majority vote, start bit value ignored here
						noise_fin   = q_ff.noise | !same3(q_ff.s8, q_ff.s9, q_ff.sync);
						nxt_q.noise = noise_fin;
						nxt_q.bitn  = q_ff.bitn + 4'h1;
						if (q_ff.bitn == (q_ff.nine ? STOP_IDX_9 : STOP_IDX_8)) begin
							nxt_q.st     = ARB_HUNT;
							nxt_q.active = 1'b0;
							xfer         = !q_ff.full;
						end else if (q_ff.bitn != '0) begin
							nxt_q.shift = {maj, q_ff.shift[8:1]};
						end
					end
				end
				default: begin
					nxt_q.st     = ARB_HUNT;
					nxt_q.active = 1'b0;
				end
			endcase
		end

		if (xfer) begin
			// ninth bit lands in bit 8 when frame-length select is one
			nxt_q.data = q_ff.nine ? q_ff.shift : {1'b0, q_ff.shift[8:1]};
			nxt_q.full = 1'b1;
			nxt_q.nf   = noise_fin;
			nxt_q.fe   = !maj;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q_ff     <= '0;
			q_ff.div <= DIV_RESET[DIV_W-1:0];
			q_ff.st  <= ARB_HUNT;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end

	assign rd_data              = q_ff.rdata;
	assign receiver_active_flag = q_ff.active;
	assign receive_full_flag    = q_ff.full;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_hunt_no_edge: assert property (ce && q_ff.en && go && q_ff.st == ARB_HUNT && !q_ff.sync && q_ff.hist != 3'b111 |=> q_ff.st == ARB_HUNT && !q_ff.active)
		else $error("start taken without three high samples");

	chk_start_entry: assert property (ce && q_ff.en && go && q_ff.st == ARB_HUNT && !q_ff.sync && q_ff.hist == 3'b111 |=> q_ff.st == ARB_START && q_ff.active && q_ff.rt == RT_FIRST && !q_ff.noise)
		else $error("start edge not labelled period one");

	chk_reject_early: assert property (ce && q_ff.en && go && q_ff.st == ARB_START && lbl == RT_5 && q_ff.s3 && q_ff.sync |=> q_ff.st == ARB_HUNT && !q_ff.active)
		else $error("high periods three and five not rejected");

	chk_period_range: assert property (q_ff.st != ARB_HUNT |-> q_ff.rt >= RT_FIRST && q_ff.rt <= RT_LAST)
		else $error("oversample period out of range");

	chk_resync_fall: assert property (ce && q_ff.en && go && q_ff.st == ARB_FRAME && fall |=> q_ff.rt == RT_FIRST)
		else $error("no resync on falling edge");

	chk_noise_report: assert property (ce && xfer |=> q_ff.full && q_ff.nf == $past(noise_fin) && q_ff.st == ARB_HUNT)
		else $error("noise not reported with receive full");

	chk_frame_error: assert property (ce && xfer && !maj |=> q_ff.fe)
		else $error("low stop bit without framing error");

	chk_data_held: assert property (ce && q_ff.full && !(rd_en && addr == DATA_OFF) |=> $stable(q_ff.data) && q_ff.full)
		else $error("receive data overwritten while full");

	chk_disable_idle: assert property (ce && !q_ff.en |=> q_ff.st == ARB_HUNT && !q_ff.active)
		else $error("receiver not idle while disabled");
endmodule

// ---- bench/arb_tx_model.sv ----
`timescale 1ns/1ns
module arb_tx_model (
	// clock
	input  wire logic ref_clk,
	// serial line, marks high when idle
	output logic      rx_pin
);
	initial rx_pin = 1'b1;

	// one frame, lsb first; gb/go pick one clock of one bit to invert
	task automatic send(input logic [8:0] d, input int nb, input int blen,
		input logic stop, input int gb, input int go);
		logic [10:0] fr;
		fr = 11'h7FF;
		fr[0] = 1'b0;
		for (int i = 0; i < nb; i++) begin
			fr[i+1] = d[i];
		end
		fr[nb+1] = stop;
		for (int b = 0; b <= nb + 1; b++) begin
			for (int o = 0; o < blen; o++) begin
				@(posedge ref_clk);
				rx_pin <= fr[b] ^ (b == gb && o == go);
			end
		end
		// idle gap gives the three high ticks a new start needs
		repeat (4) begin
			@(posedge ref_clk);
			rx_pin <= 1'b1;
		end
	endtask

	// short low glitch, then mark
	task automatic pulse(input int w);
		for (int i = 0; i < w + 8; i++) begin
			@(posedge ref_clk);
			rx_pin <= (i >= w);
		end
	endtask
endmodule

// ---- bench/test_arb_rx_bit.sv ----
`timescale 1ns/1ns
module test_arb_rx_bit import arb_pkg::*; ;
	logic              ref_clk;
	logic              rst;
	logic              ce;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic              wr_en;
	logic              rd_en;
	logic [DATA_W-1:0] rd_data;
	logic              rx_pin;
	logic              receiver_active_flag;
	logic              receive_full_flag;
	int                err_total = 0;
	int                comparisons = 0;
	logic [15:0]       q;
	logic [8:0]        d;
	int                b;

	arb_rx_bit #(.DIV_W(16)) arb_rx_bit_i (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin),
		.receiver_active_flag(receiver_active_flag),
		.receive_full_flag(receive_full_flag));
	arb_tx_model arb_tx_model_i (.ref_clk(ref_clk), .rx_pin(rx_pin));

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	task automatic finish_test;
		if (err_total == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	function automatic logic [15:0] stat_exp(input logic nf, input logic fe);
		stat_exp = 16'h0000;
		stat_exp[FULL_POS] = 1'b1;
		stat_exp[NOISE_POS] = nf;
		stat_exp[FRAME_POS] = fe;
	endfunction

	function automatic logic [15:0] data_exp(input logic [8:0] v, input int nb);
		data_exp = (nb == 9) ? {7'h00, v} : {8'h00, v[7:0]};
	endfunction

	task automatic frame(input logic [8:0] v, input int nb, input int blen,
		input logic stop, input int gb, input int go, input logic nf);
		arb_tx_model_i.send(v, nb, blen, stop, gb, go);
		chk_bit(receive_full_flag, 1'b1, "full");
		rd(STAT_OFF, q);
		chk_word(q, stat_exp(nf, ~stop), "status");
		rd(DATA_OFF, q);
		chk_word(q, data_exp(v, nb), "data");
		@(posedge ref_clk);
		#1 chk_bit(receive_full_flag, 1'b0, "cleared");
	endtask

	initial begin
		#200_000;
		err_total++;
		finish_test();
	end

	initial begin
		ce = 1'b1;
		rst = 1'b1;
		addr = '0;
		wr_data = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		void'($urandom(32'h0EE3AD8F));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(STAT_OFF, q);
		chk_word(q, 16'h0000, "reset status");
		rd(DIV_OFF, q);
		chk_word(q, DIV_RESET, "divider reset");
		wr(4'h2, 16'hFFFF);
		rd(4'h2, q);
		chk_word(q, 16'h0000, "unmapped");
		// tick every clock keeps frames short
		wr(DIV_OFF, 16'h0000);
		wr(CTRL_OFF, 16'h0001);
		// history starts low, so the hunt needs three high ticks first
		repeat (8) @(posedge ref_clk);
		repeat (6) frame(9'($urandom), 8, 16, 1'b1, -1, 0, 1'b0);
		wr(CTRL_OFF, 16'h0003);
		repeat (3) frame(9'($urandom), 9, 16, 1'b1, -1, 0, 1'b0);
		wr(CTRL_OFF, 16'h0001);
		frame(9'($urandom), 8, 16, 1'b0, -1, 0, 1'b0);
		// high glitch at period ten of a low bit, any of the eight data bits
		repeat (4) begin
			b = $urandom_range(1, 8);
			d = 9'($urandom);
			d[b-1] = 1'b0;
			frame(d, 8, 16, 1'b1, b, 9, 1'b1);
		end
		frame(9'h0A5, 8, 16, 1'b1, 0, 4, 1'b1);
		for (int w = 2; w <= 3; w++) begin
			arb_tx_model_i.pulse(w);
			frame(9'($urandom), 8, 16, 1'b1, -1, 0, 1'b0);
		end
		// off-rate sender only survives through resync on falls
		for (int l = 15; l <= 17; l += 2) frame(9'h055, 8, l, 1'b1, -1, 0, 1'b0);
		// second frame while full is dropped
		arb_tx_model_i.send(9'h03C, 8, 16, 1'b1, -1, 0);
		arb_tx_model_i.send(9'h0C3, 8, 16, 1'b1, -1, 0);
		chk_bit(receive_full_flag, 1'b1, "full kept");
		rd(STAT_OFF, q);
		chk_word(q, stat_exp(1'b0, 1'b0), "status kept");
		rd(DATA_OFF, q);
		chk_word(q, 16'h003C, "first kept");
		fork
			arb_tx_model_i.send(9'h0F0, 8, 16, 1'b1, -1, 0);
			begin
				repeat (40) @(posedge ref_clk);
				#1 chk_bit(receiver_active_flag, 1'b1, "active");
				wr(CTRL_OFF, 16'h0000);
				repeat (3) @(posedge ref_clk);
				#1 chk_bit(receiver_active_flag, 1'b0, "disabled");
			end
		join
		chk_bit(receive_full_flag, 1'b0, "no partial");
		wr(CTRL_OFF, 16'h0001);
		repeat (8) @(posedge ref_clk);
		frame(9'($urandom), 8, 16, 1'b1, -1, 0, 1'b0);
		finish_test();
	end
endmodule
